// *** rtl/irq_bank_pkg.sv ***
// Purpose: constants and types shared by the interrupt source control bank
// Assumes: 32-bit classic Wishbone register access, one clock
// Notes:   source word layout is the same for every register pair
package irq_bank_pkg;

    localparam int          DATA_W = 32;
    localparam int          ADDR_W = 8;
    localparam int          NUM_SRC = 64;

    // register byte offsets
    localparam logic [7:0]  OFS_ENABLE_LO = 8'h10;
    localparam logic [7:0]  OFS_ENABLE_HI = 8'h14;
    localparam logic [7:0]  OFS_REQUEST_LO = 8'h20;
    localparam logic [7:0]  OFS_REQUEST_HI = 8'h24;
    localparam logic [7:0]  OFS_CLEAR_LO = 8'h30;
    localparam logic [7:0]  OFS_CLEAR_HI = 8'h34;
    localparam logic [7:0]  OFS_ARM_LO = 8'h40;
    localparam logic [7:0]  OFS_ARM_HI = 8'h44;
    localparam logic [7:0]  OFS_LEVEL_LO = 8'h50;
    localparam logic [7:0]  OFS_LEVEL_HI = 8'h54;
    localparam logic [7:0]  OFS_POLARITY_LO = 8'h60;
    localparam logic [7:0]  OFS_POLARITY_HI = 8'h64;

    // implemented bits: first word timers 7:0, external 15:8, aux 22:20, cable 31:24
    localparam logic [31:0] MASK_LO = 32'hFF70FFFF;
    // second word: external 11:8 at 11:8, cable 11:8 at 27:24
    localparam logic [31:0] MASK_HI = 32'h0F000F00;
    localparam logic [63:0] MASK_ALL = {MASK_HI, MASK_LO};

    localparam logic [31:0] RESET_WORD = 32'h00000000;
    localparam logic [31:0] READ_UNMAPPED = 32'h00000000;

    // source inputs grouped by origin
    typedef struct packed {
        logic [11:0] cableInterrupt;
        logic [11:0] externalEdgeInterrupt;
        logic [2:0]  auxInterrupt;     // 2: rx full, 1: tx empty, 0: one pps
        logic [7:0]  timerInterrupt;
    } irq_sources_t;

    typedef struct packed {
        logic [ADDR_W-1:0] adr;
        logic [DATA_W-1:0] dat;
        logic [3:0]        sel;
        logic              we;
        logic              cyc;
        logic              stb;
    } wb_request_t;

    // place grouped sources into the 64-bit lo/hi register image
    function automatic logic [63:0] map_sources(input irq_sources_t s);
        logic [63:0] v;
        v = '0;
        v[7:0] = s.timerInterrupt;
        v[15:8] = s.externalEdgeInterrupt[7:0];
        v[22:20] = s.auxInterrupt;
        v[31:24] = s.cableInterrupt[7:0];
        v[43:40] = s.externalEdgeInterrupt[11:8];
        v[59:56] = s.cableInterrupt[11:8];
        return v;
    endfunction

endpackage

// *** rtl/irq_source_cell.sv ***
// Purpose: one interrupt source: detection, arming and pending capture
// Assumes: source input synchronous to clk_sys
// Notes:   set wins over clear in the same cycle
`timescale 1ns/100ps
module irq_source_cell
    import irq_bank_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // source and controls
    input  wire logic srcIn,
    input  wire logic levelMode,
    input  wire logic activeHigh,
    input  wire logic armed,
    input  wire logic softRequest,
    input  wire logic clearReq,
    // status
    output logic      pending
);

    logic srcPrev;
    logic senseNow;
    logic sensePrev;
    logic hwEvent;

    assign senseNow = activeHigh ? srcIn : ~srcIn;
    assign sensePrev = activeHigh ? srcPrev : ~srcPrev;
    assign hwEvent = levelMode ? senseNow : (armed & senseNow & ~sensePrev);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            srcPrev <= 1'b0;
        end else begin
            srcPrev <= srcIn;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pending <= 1'b0;
        end else if (hwEvent || softRequest) begin
            pending <= 1'b1;
        end else if (clearReq) begin
            pending <= 1'b0;
        end
    end

endmodule

// *** rtl/interrupt_source_control.sv ***
// Purpose: interrupt source control bank behind a classic Wishbone slave
// Assumes: 40 MHz clk_sys, synchronous active-high rst, sources synchronous
// Notes:   ack comes one cycle after stb, dropped the cycle after
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/100ps
module interrupt_source_control
    import irq_bank_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [DATA_W-1:0] wb_dat_i,
    input  wire logic [3:0]        wb_sel_i,
    output logic      [DATA_W-1:0] wb_dat_o,
    output logic                   wb_ack_o,
    // interrupt sources
    input  wire irq_sources_t      sources,
    // host interrupt
    output logic                   irqOut
);

    typedef enum {
        REG_ENABLE,
        REG_REQUEST,
        REG_CLEAR,
        REG_ARM,
        REG_LEVEL,
        REG_POLARITY,
        REG_NONE
    } reg_sel_t;

    wb_request_t req;
    logic [63:0] enable;
    logic [63:0] arm;
    logic [63:0] levelSel;
    logic [63:0] polarity;
    logic [63:0] clearShadow;
    logic [63:0] pendingVec;
    logic [63:0] srcVec;
    logic [63:0] softPulse;
    logic [63:0] clearPulse;
    logic [31:0] byteMask;
    logic        accessNow;
    logic        writeNow;
    reg_sel_t    hitReg;
    logic        hitHi;

    assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i,
                   we: wb_we_i, cyc: wb_cyc_i, stb: wb_stb_i};

    function automatic reg_sel_t decode_reg(input logic [ADDR_W-1:0] a);
        if (a == OFS_ENABLE_LO || a == OFS_ENABLE_HI) begin
            return REG_ENABLE;
        end else if (a == OFS_REQUEST_LO || a == OFS_REQUEST_HI) begin
            return REG_REQUEST;
        end else if (a == OFS_CLEAR_LO || a == OFS_CLEAR_HI) begin
            return REG_CLEAR;
        end else if (a == OFS_ARM_LO || a == OFS_ARM_HI) begin
            return REG_ARM;
        end else if (a == OFS_LEVEL_LO || a == OFS_LEVEL_HI) begin
            return REG_LEVEL;
        end else if (a == OFS_POLARITY_LO || a == OFS_POLARITY_HI) begin
            return REG_POLARITY;
        end else begin
            return REG_NONE;
        end
    endfunction

    // the high word of every pair sits one word above the low word
    function automatic logic is_hi_word(input logic [ADDR_W-1:0] a);
        return a[2];
    endfunction

    assign hitReg = decode_reg(req.adr);
    assign hitHi = is_hi_word(req.adr);
    assign accessNow = req.cyc && req.stb && !wb_ack_o;
    // writes commit on the edge where the master samples ack, not one edge earlier
    assign writeNow = req.cyc && req.stb && req.we && wb_ack_o;
    assign byteMask = {{8{req.sel[3]}}, {8{req.sel[2]}}, {8{req.sel[1]}}, {8{req.sel[0]}}};

    assign srcVec = map_sources(sources) & MASK_ALL;

    // merge a written word into one half of a 64-bit register
    function automatic logic [63:0] merge_word(input logic [63:0] old,
                                               input logic [31:0] data,
                                               input logic [31:0] bmask,
                                               input logic        hi);
        logic [63:0] r;
        r = old;
        if (hi) begin
            r[63:32] = ((old[63:32] & ~bmask) | (data & bmask)) & MASK_HI;
        end else begin
            r[31:0] = ((old[31:0] & ~bmask) | (data & bmask)) & MASK_LO;
        end
        return r;
    endfunction

    // write-one pulse for request and clear functions
    function automatic logic [63:0] one_pulse(input logic [31:0] data,
                                              input logic [31:0] bmask,
                                              input logic        hi);
        logic [63:0] r;
        r = '0;
        if (hi) begin
            r[63:32] = data & bmask & MASK_HI;
        end else begin
            r[31:0] = data & bmask & MASK_LO;
        end
        return r;
    endfunction

    // wishbone ack: one wait state, then a single-cycle ack
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= accessNow;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enable <= {RESET_WORD, RESET_WORD};
        end else if (writeNow && hitReg == REG_ENABLE) begin
            enable <= merge_word(enable, req.dat, byteMask, hitHi);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            arm <= {RESET_WORD, RESET_WORD};
        end else if (writeNow && hitReg == REG_ARM) begin
            arm <= merge_word(arm, req.dat, byteMask, hitHi);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            levelSel <= {RESET_WORD, RESET_WORD};
        end else if (writeNow && hitReg == REG_LEVEL) begin
            levelSel <= merge_word(levelSel, req.dat, byteMask, hitHi);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            polarity <= {RESET_WORD, RESET_WORD};
        end else if (writeNow && hitReg == REG_POLARITY) begin
            polarity <= merge_word(polarity, req.dat, byteMask, hitHi);
        end
    end

    // clear pair reads back the last word written, for software bookkeeping
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clearShadow <= {RESET_WORD, RESET_WORD};
        end else if (writeNow && hitReg == REG_CLEAR) begin
            clearShadow <= merge_word(clearShadow, req.dat, byteMask, hitHi);
        end
    end

    // write to shared offset raises requests
    assign softPulse = (writeNow && hitReg == REG_REQUEST)
                     ? one_pulse(req.dat, byteMask, hitHi) : '0;
    // write-one clear, zeros leave others alone
    assign clearPulse = (writeNow && hitReg == REG_CLEAR)
                      ? one_pulse(req.dat, byteMask, hitHi) : '0;

    genvar i;
    generate
        for (i = 0; i < NUM_SRC; i++) begin : g_src
            if (MASK_ALL[i]) begin : g_live
                irq_source_cell u_cell (
                    .clk_sys     (clk_sys),
                    .rst         (rst),
                    .srcIn       (srcVec[i]),
                    .levelMode   (levelSel[i]),
                    .activeHigh  (polarity[i]),
                    .armed       (arm[i]),
                    .softRequest (softPulse[i]),
                    .clearReq    (clearPulse[i]),
                    .pending     (pendingVec[i])
                );
            end else begin : g_rsvd
                assign pendingVec[i] = 1'b0;
            end
        end
    endgenerate

    // read mux, pending at the request offset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wb_dat_o <= READ_UNMAPPED;
        end else if (accessNow && !req.we) begin
            case (hitReg)
                REG_ENABLE:   wb_dat_o <= hitHi ? enable[63:32] : enable[31:0];
                REG_REQUEST:  wb_dat_o <= hitHi ? pendingVec[63:32] : pendingVec[31:0];
                REG_CLEAR:    wb_dat_o <= hitHi ? clearShadow[63:32] : clearShadow[31:0];
                REG_ARM:      wb_dat_o <= hitHi ? arm[63:32] : arm[31:0];
                REG_LEVEL:    wb_dat_o <= hitHi ? levelSel[63:32] : levelSel[31:0];
                REG_POLARITY: wb_dat_o <= hitHi ? polarity[63:32] : polarity[31:0];
                default:      wb_dat_o <= READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqOut <= 1'b0;
        end else begin
            irqOut <= |(pendingVec & enable);
        end
    end

endmodule

// *** verification/irq_bank_checker.sv ***
// Purpose: port assertions for the interrupt source bank
// Assumes: partial lane enable writes may occur
// Notes:   enable mirror is rebuilt from bus writes
`timescale 1ns/100ps
module irq_bank_checker
    import irq_bank_pkg::*;
(
    // clock and reset
    input wire logic              clk_sys,
    input wire logic              rst,
    // bus
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [DATA_W-1:0] wb_dat_o,
    input wire logic              wb_ack_o,
    // sources and host interrupt
    input wire irq_sources_t      sources,
    input wire logic              irqOut
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [31:0] enLo;
    logic [31:0] enHi;
    logic        isMapped;
    logic        rdAck;
    assign isMapped = wb_adr_i[7:4] inside {[4'h1:4'h6]} && wb_adr_i[3:0] inside {4'h0, 4'h4};
    assign rdAck = wb_ack_o && !wb_we_i;
    // partial lane writes count as enabled, so the gate check stays safe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enLo <= 32'h00000000;
            enHi <= 32'h00000000;
        end else if (wb_ack_o && wb_we_i && wb_adr_i == OFS_ENABLE_LO) begin
            enLo <= (wb_sel_i == 4'hF) ? wb_dat_i : 32'hFFFFFFFF;
        end else if (wb_ack_o && wb_we_i && wb_adr_i == OFS_ENABLE_HI) begin
            enHi <= (wb_sel_i == 4'hF) ? wb_dat_i : 32'hFFFFFFFF;
        end
    end
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    reset_quiet_a: assert property (disable iff (1'b0) rst |=> !wb_ack_o && !irqOut)
        else $error("outputs active after reset");
    unmapped_zero_a: assert property (rdAck && !isMapped |-> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    reserved_lo_a: assert property (rdAck && isMapped && !wb_adr_i[2]
        |-> (wb_dat_o & ~MASK_LO) == 32'h00000000)
        else $error("reserved first word bits set");
    reserved_hi_a: assert property (rdAck && isMapped && wb_adr_i[2]
        |-> (wb_dat_o & ~MASK_HI) == 32'h00000000)
        else $error("reserved second word bits set");
    irq_gated_a: assert property ((enLo & MASK_LO) == 0 && (enHi & MASK_HI) == 0
        && $past((enLo & MASK_LO) == 0 && (enHi & MASK_HI) == 0) |-> !irqOut)
        else $error("interrupt with no source enabled");
    data_hold_a: assert property (!rdAck |-> $stable(wb_dat_o))
        else $error("read data changed without a read");
    cover property (wb_ack_o && wb_we_i);
    cover property (rdAck && !isMapped);
    cover property ($rose(irqOut));
endmodule

// *** verification/irq_source_model.sv ***
// Purpose: far-side model of the interrupt sources
// Assumes: bench sets the wanted pattern between edges
// Notes:   real sources change only on clk_sys edges
`timescale 1ns/100ps
module irq_source_model
    import irq_bank_pkg::*;
(
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // wanted and driven pattern
    input  wire irq_sources_t want,
    output irq_sources_t      sources
);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sources <= '0;
        end else begin
            sources <= want;
        end
    end
endmodule

// *** verification/tb_interrupt_source_control.sv ***
// Purpose: register and source tests of the interrupt bank
// Assumes: single Wishbone master, byte lanes set per call
// Notes:   clear writes in clearAll are followed by zero writes
`timescale 1ns/100ps
module tb_interrupt_source_control
    import irq_bank_pkg::*;
;
    logic         clk_sys;
    logic         rst;
    logic         busCyc;
    logic         busStb;
    logic         busWe;
    logic [3:0]   busSel;
    logic [3:0]   laneSel;
    logic [7:0]   busAdr;
    logic [31:0]  busDat;
    logic [31:0]  rdData;
    logic         ack;
    logic         irq;
    logic [31:0]  q;
    irq_sources_t want;
    irq_sources_t sources;
    int           numErrors;
    int           testsRun;
    logic [7:0]   allOfs [12] = '{OFS_ENABLE_LO, OFS_ENABLE_HI, OFS_REQUEST_LO, OFS_REQUEST_HI,
        OFS_CLEAR_LO, OFS_CLEAR_HI, OFS_ARM_LO, OFS_ARM_HI, OFS_LEVEL_LO, OFS_LEVEL_HI,
        OFS_POLARITY_LO, OFS_POLARITY_HI};

    interrupt_source_control DUT (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(busCyc),
        .wb_stb_i(busStb), .wb_we_i(busWe), .wb_adr_i(busAdr), .wb_dat_i(busDat),
        .wb_sel_i(busSel), .wb_dat_o(rdData), .wb_ack_o(ack), .sources(sources), .irqOut(irq));
    irq_source_model partner (.clk_sys(clk_sys), .rst(rst), .want(want), .sources(sources));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        busCyc <= 1'b1;
        busStb <= 1'b1;
        busWe <= we;
        busAdr <= a;
        busDat <= d;
        busSel <= laneSel;
        // no cycle limit here: only the watchdog ends a wait for ack
        do begin
            @(posedge clk_sys);
        end while (ack !== 1'b1);
        q = rdData;
        busCyc <= 1'b0;
        busStb <= 1'b0;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            numErrors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic readCheck(input string name, input logic [7:0] a, input logic [31:0] exp);
        wbXfer(1'b0, a, 32'h00000000);
        check(name, exp, q);
    endtask

    task automatic clearAll();
        wbXfer(1'b1, OFS_CLEAR_LO, 32'hFFFFFFFF);
        wbXfer(1'b1, OFS_CLEAR_HI, 32'hFFFFFFFF);
        wbXfer(1'b1, OFS_CLEAR_LO, 32'h00000000);
        wbXfer(1'b1, OFS_CLEAR_HI, 32'h00000000);
    endtask

    task automatic setSrc(input irq_sources_t v);
        want <= v;
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic stopTest();
        $display("errors %0d checks %0d", numErrors, testsRun);
        if (numErrors == 0 && testsRun > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        numErrors++;
        stopTest();
    end

    initial begin
        rst = 1'b1;
        busCyc = 1'b0;
        busStb = 1'b0;
        busWe = 1'b0;
        busSel = 4'hF;
        laneSel = 4'hF;
        busAdr = 8'h00;
        busDat = 32'h00000000;
        want = '0;
        numErrors = 0;
        testsRun = 0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (allOfs[i]) readCheck("reset value", allOfs[i], 32'h00000000);
        // level with low polarity makes idle-low sources pending
        foreach (allOfs[i]) if (allOfs[i][7:4] != 4'h2) begin
            wbXfer(1'b1, allOfs[i], 32'hFFFFFFFF);
            readCheck("mask", allOfs[i], allOfs[i][2] ? MASK_HI : MASK_LO);
            wbXfer(1'b1, allOfs[i], 32'h00000000);
        end
        readCheck("low level lo", OFS_REQUEST_LO, MASK_LO);
        readCheck("low level hi", OFS_REQUEST_HI, MASK_HI);
        clearAll();
        readCheck("cleared", OFS_REQUEST_LO, 32'h00000000);
        wbXfer(1'b1, 8'h18, 32'hFFFFFFFF);
        readCheck("unmapped", 8'h18, 32'h00000000);
        wbXfer(1'b1, OFS_REQUEST_HI, 32'hFFFFFFFF);
        readCheck("soft hi", OFS_REQUEST_HI, MASK_HI);
        wbXfer(1'b1, OFS_REQUEST_LO, 32'h00000001);
        readCheck("soft lo", OFS_REQUEST_LO, 32'h00000001);
        check("irq disabled", 32'h0, {31'h0, irq});
        wbXfer(1'b1, OFS_ENABLE_LO, 32'h00000001);
        repeat (2) @(posedge clk_sys);
        check("irq enabled", 32'h1, {31'h0, irq});
        wbXfer(1'b1, OFS_CLEAR_LO, 32'h00000001);
        readCheck("selective lo", OFS_REQUEST_LO, 32'h00000000);
        readCheck("selective hi", OFS_REQUEST_HI, MASK_HI);
        check("irq cleared", 32'h0, {31'h0, irq});
        clearAll();
        wbXfer(1'b1, OFS_POLARITY_LO, 32'h00000001);
        setSrc(irq_sources_t'(35'h1));
        setSrc('0);
        readCheck("disarmed", OFS_REQUEST_LO, 32'h00000000);
        wbXfer(1'b1, OFS_ARM_LO, 32'h00000001);
        setSrc(irq_sources_t'(35'h1));
        readCheck("rising", OFS_REQUEST_LO, 32'h00000001);
        clearAll();
        wbXfer(1'b1, OFS_POLARITY_LO, 32'h00000000);
        setSrc(irq_sources_t'(35'h0));
        readCheck("falling", OFS_REQUEST_LO, 32'h00000001);
        clearAll();
        foreach (allOfs[i]) if (allOfs[i][7:4] >= 4'h5) wbXfer(1'b1, allOfs[i ^ 2], 32'hFFFFFFFF);
        setSrc({12'h801, 12'h801, 3'b101, 8'h81});
        readCheck("map lo", OFS_REQUEST_LO, 32'h01500181);
        readCheck("map hi", OFS_REQUEST_HI, 32'h08000800);
        clearAll();
        readCheck("level holds", OFS_REQUEST_LO, 32'h01500181);
        setSrc('0);
        clearAll();
        readCheck("level gone", OFS_REQUEST_LO, 32'h00000000);
        // byte lanes limit what a write touches
        laneSel = 4'h2;
        wbXfer(1'b1, OFS_ENABLE_LO, 32'hFFFFFFFF);
        laneSel = 4'h1;
        wbXfer(1'b1, OFS_REQUEST_LO, 32'h0000FF02);
        laneSel = 4'hF;
        readCheck("lane enable", OFS_ENABLE_LO, 32'h0000FF01);
        readCheck("lane request", OFS_REQUEST_LO, 32'h00000002);
        // reset again in mid-run
        rst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        readCheck("reset enable", OFS_ENABLE_LO, 32'h00000000);
        readCheck("reset pending", OFS_REQUEST_LO, 32'h00000000);
        stopTest();
    end
endmodule

bind interrupt_source_control irq_bank_checker chk (.clk_sys(clk_sys), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sources(sources), .irqOut(irqOut));
